// ---- common/adcseq_defines.svh ----
// register offsets, field positions, reset values and timing for the conversion sequencer
`ifndef ADCSEQ_DEFINES_SVH
`define ADCSEQ_DEFINES_SVH
// register byte addresses (ahb word per register)
// register index is the word number, byte address is four times the index
`define ADCSEQ_IDX_CONTROL_A 0
`define ADCSEQ_IDX_CONFIG 1
`define ADCSEQ_OFF_CONTROL_A 12'(4 * `ADCSEQ_IDX_CONTROL_A)
`define ADCSEQ_OFF_CONFIG 12'(4 * `ADCSEQ_IDX_CONFIG)
`define ADCSEQ_OFF_REFERENCE 12'h008
`define ADCSEQ_OFF_PRESC 12'h00c
`define ADCSEQ_OFF_GAIN 12'h010
`define ADCSEQ_OFF_EVCTRL 12'h014
`define ADCSEQ_OFF_FLAGS 12'h018
`define ADCSEQ_OFF_RESULT 12'h01c
`define ADCSEQ_OFF_CMP 12'h020
// control register a fields
`define ADCSEQ_A_ENABLE 0
`define ADCSEQ_A_FLUSH 1
`define ADCSEQ_A_START 2
// conversion config fields
`define ADCSEQ_B_RES_LO 1
`define ADCSEQ_B_RES_HI 2
`define ADCSEQ_B_CONTINUOUS 3
`define ADCSEQ_B_SIGNED 4
`define ADCSEQ_B_MASK 8'h1e
// reference control fields
`define ADCSEQ_R_TEMP 0
`define ADCSEQ_R_BGAP 1
`define ADCSEQ_R_SEL_LO 4
`define ADCSEQ_R_SEL_HI 6
`define ADCSEQ_R_MASK 8'h73
// event control fields
`define ADCSEQ_E_ENABLE 0
`define ADCSEQ_E_MASK 8'h01
// flags / compare fields
`define ADCSEQ_F_DONE 0
`define ADCSEQ_F_CMPEN 1
`define ADCSEQ_F_ABOVE 2
// reset values
`define ADCSEQ_RST_8 8'h00
// fixed converter clock cycles per conversion, added to half the resolution and the gain cycles
`define ADCSEQ_BASE_CYC 1
`define ADCSEQ_PRESC_MIN_LOG2 2
`endif

// ---- common/adcseq_pkg.sv ----
// types shared by the conversion sequencer
package adcseq_pkg;
    // sequencer states
    typedef enum logic [1:0] {
        ADCSEQ_IDLE = 2'b00,
        ADCSEQ_WAIT = 2'b01,
        ADCSEQ_CONV = 2'b10
    } adcseq_state_e;
    // resolution encodings
    typedef enum logic [1:0] {
        ADCSEQ_TWELVE_BIT_RIGHT = 2'b00,
        ADCSEQ_RES_RSVD = 2'b01,
        ADCSEQ_EIGHT_BIT_RIGHT = 2'b10,
        ADCSEQ_TWELVE_BIT_LEFT = 2'b11
    } adcseq_res_e;
endpackage

// ---- rtl/adcseq_top.sv ----
// conversion sequencer: ahb-lite registers, prescaler and conversion timing
`timescale 1ns/10ps
`include "adcseq_defines.svh"

// Behaviour
// - converter clock from programmable prescaler divider
// - conversion lasts one plus half resolution plus gain
// - gain adds one, two or three cycles
// - start seen a clock before converter edge
// - input sampled in first half cycle
// - msb first, rest in 3 or 5
// - last cycle prepares result, then done flag
// - gain stage samples half cycle first
// - conversions never overlap
// - irq and event on done or compare
// - start bit requests, hardware clears on start
// - flush aborts conversion and restarts clock
// - enable bit turns converter on
// - sign mode bit selects signed/unsigned
// - free running restarts after each conversion
// - resolution field selects format and alignment
// - reference select field chooses reference
// - bandgap bit powers bandgap
// - temperature bit enables temperature reference
// - signed results sign extended
// - selected event can start conversion
// - done flag cleared by vector or write-one
module adcseq_top #(
    parameter int DATA_BITS = 12 // converter result width
) (
    input wire logic hclk, // peripheral clock
    input wire logic hresetn, // async reset, active low
    input wire logic clk_en, // freezes all state when low
    input wire logic hsel, // slave select
    input wire logic [11:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp, // always okay
    input wire logic trig_event, // routed start event, one-cycle pulse
    input wire logic irq_ack, // interrupt vector executing
    input wire logic [11:0] core_data, // converted code from analog core
    output logic conv_clk, // prescaled converter clock
    output logic sample_en, // sample window (first half cycle)
    output logic gain_sample_en, // gain stage sample window
    output logic conv_busy, // conversion running
    output logic conv_irq, // interrupt request level
    output logic conv_event, // one-cycle event out
    output logic signed_mode, // signed conversion selected
    output logic [2:0] ref_sel, // reference select
    output logic bandgap_en, // bandgap power
    output logic temp_en, // temperature reference power
    output logic conv_enable // converter enabled
);
    // ========================================
    // elaboration checks
    if (DATA_BITS != 12)
    begin : g_chk
        $error("adcseq_top serves only 12-bit results");
    end

    // ========================================
    // registers
    logic en_r; // converter enable
    logic start_r; // pending software start
    logic [7:0] cfg_r; // conversion config
    logic [7:0] ref_r; // reference control
    logic [2:0] presc_r; // prescaler select
    logic [2:0] gain_r; // gain setting, 0 = none
    logic [7:0] ev_r; // event control
    logic done_r; // done flag
    logic cmpen_r; // compare mode enable
    logic above_r; // compare: fire when above
    logic [15:0] cmp_r; // compare threshold
    logic [15:0] res_r; // result register
    logic [8:0] div_r; // prescaler counter
    logic [4:0] cyc_r; // converter cycles remaining
    adcseq_pkg::adcseq_state_e st_r; // sequencer state
    logic evpend_r; // latched event start
    // ahb data phase
    logic dp_wr_r; // write data phase pending
    logic dp_rd_r; // read data phase pending
    logic [11:0] dp_addr_r; // latched address

    // ========================================
    // bus decode
    wire logic addr_ph = hsel && hready && htrans[1]; // valid address phase
    wire logic wr = dp_wr_r && clk_en; // write data phase
    wire logic wr_a = wr && (dp_addr_r == `ADCSEQ_OFF_CONTROL_A); // control a write
    wire logic wr_flush = wr_a && hwdata[`ADCSEQ_A_FLUSH]; // flush request
    wire logic wr_start = wr_a && hwdata[`ADCSEQ_A_START]; // software start
    wire logic clr_done = irq_ack || (wr && (dp_addr_r == `ADCSEQ_OFF_FLAGS)
        && hwdata[`ADCSEQ_F_DONE]); // flag clear
    logic [31:0] rd_mux; // read selection
    always_comb
    begin
        case (dp_addr_r)
            `ADCSEQ_OFF_CONTROL_A: rd_mux = {29'h0, start_r, 1'b0, en_r};
            `ADCSEQ_OFF_CONFIG: rd_mux = {24'h0, cfg_r};
            `ADCSEQ_OFF_REFERENCE: rd_mux = {24'h0, ref_r};
            `ADCSEQ_OFF_PRESC: rd_mux = {29'h0, presc_r};
            `ADCSEQ_OFF_GAIN: rd_mux = {29'h0, gain_r};
            `ADCSEQ_OFF_EVCTRL: rd_mux = {24'h0, ev_r};
            `ADCSEQ_OFF_FLAGS: rd_mux = {29'h0, above_r, cmpen_r, done_r};
            `ADCSEQ_OFF_RESULT: rd_mux = {16'h0, res_r};
            `ADCSEQ_OFF_CMP: rd_mux = {16'h0, cmp_r};
            default: rd_mux = 32'h0;
        endcase
    end

    // ========================================
    // conversion length and prescaler
    wire adcseq_pkg::adcseq_res_e res_mode = adcseq_pkg::adcseq_res_e'(
        cfg_r[`ADCSEQ_B_RES_HI:`ADCSEQ_B_RES_LO]); // result format
    wire logic eight = (res_mode == adcseq_pkg::ADCSEQ_EIGHT_BIT_RIGHT); // 8-bit mode
    wire logic [4:0] gain_cyc = (gain_r == 3'h0) ? 5'h0 : (gain_r <= 3'h2) ? 5'h1 :
        (gain_r <= 3'h4) ? 5'h2 : 5'h3; // 1:2x/4x 2:8x/16x 3:32x/64x
    wire logic [4:0] total_cyc = 5'(`ADCSEQ_BASE_CYC) + (eight ? 5'h4 : 5'h6) + gain_cyc;
    // divider terminal value, divide by 2^(presc+2)
    // shift amount kept at 4 bits so settings 6 and 7 do not wrap
    wire logic [3:0] div_log2 = 4'(presc_r) + 4'(`ADCSEQ_PRESC_MIN_LOG2); // log2 of divider
    wire logic [8:0] div_top = 9'((10'h1 << div_log2) - 10'h1);
    // last peripheral cycle; >= recovers at once after a smaller prescaler
    wire logic tick = (div_r >= div_top);
    wire logic first_half = (div_r <= 9'(div_top >> 1)); // first half of converter cycle
    wire logic go = en_r && (start_r || evpend_r); // pending start
    // code formatting with alignment and sign extension
    wire logic sgn = cfg_r[`ADCSEQ_B_SIGNED]; // signed mode
    wire logic [15:0] fmt = eight ? {{8{sgn & core_data[11]}}, core_data[11:4]} :
        (res_mode == adcseq_pkg::ADCSEQ_TWELVE_BIT_LEFT) ? {core_data, 4'h0} :
        {{4{sgn & core_data[11]}}, core_data};
    wire logic cmp_hit = sgn ? (above_r ? ($signed(fmt) > $signed(cmp_r)) :
        ($signed(fmt) < $signed(cmp_r))) : (above_r ? (fmt > cmp_r) : (fmt < cmp_r));
    wire logic finish = (st_r == adcseq_pkg::ADCSEQ_CONV) && tick && (cyc_r == 5'h1);
    wire logic fire = finish && (!cmpen_r || cmp_hit); // flag / event condition

    // ========================================
    // ahb slave pipeline
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr_r <= 1'b0;
            dp_rd_r <= 1'b0;
            dp_addr_r <= 12'h0;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else if (clk_en)
        begin
            dp_wr_r <= addr_ph && hwrite;
            dp_rd_r <= addr_ph && !hwrite;
            // one wait state on reads, so hrdata stands when hready is high
            hreadyout <= !(addr_ph && !hwrite);
            hresp <= 1'b0;
            if (addr_ph)
            begin
                dp_addr_r <= {haddr[11:2], 2'b00};
            end
            if (dp_rd_r)
            begin
                hrdata <= rd_mux;
            end
        end
    end

    // ========================================
    // configuration registers
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            en_r <= 1'b0;
            cfg_r <= `ADCSEQ_RST_8;
            ref_r <= `ADCSEQ_RST_8;
            presc_r <= 3'h0;
            gain_r <= 3'h0;
            ev_r <= `ADCSEQ_RST_8;
            cmpen_r <= 1'b0;
            above_r <= 1'b0;
            cmp_r <= 16'h0;
        end
        else if (wr)
        begin
            case (dp_addr_r)
                `ADCSEQ_OFF_CONTROL_A: en_r <= hwdata[`ADCSEQ_A_ENABLE];
                `ADCSEQ_OFF_CONFIG: cfg_r <= hwdata[7:0] & `ADCSEQ_B_MASK;
                `ADCSEQ_OFF_REFERENCE: ref_r <= hwdata[7:0] & `ADCSEQ_R_MASK;
                `ADCSEQ_OFF_PRESC: presc_r <= hwdata[2:0];
                `ADCSEQ_OFF_GAIN: gain_r <= hwdata[2:0];
                `ADCSEQ_OFF_EVCTRL: ev_r <= hwdata[7:0] & `ADCSEQ_E_MASK;
                `ADCSEQ_OFF_FLAGS:
                begin
                    cmpen_r <= hwdata[`ADCSEQ_F_CMPEN];
                    above_r <= hwdata[`ADCSEQ_F_ABOVE];
                end
                `ADCSEQ_OFF_CMP: cmp_r <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // ========================================
    // start requests, prescaler and sequencer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            start_r <= 1'b0;
            evpend_r <= 1'b0;
            div_r <= 9'h0;
            cyc_r <= 5'h0;
            st_r <= adcseq_pkg::ADCSEQ_IDLE;
            res_r <= 16'h0;
            done_r <= 1'b0;
            conv_event <= 1'b0;
        end
        else if (clk_en)
        begin
            conv_event <= fire;
            if (fire)
            begin
                done_r <= 1'b1;
            end
            else if (clr_done)
            begin
                done_r <= 1'b0;
            end
            // event start latched only while enabled
            if (en_r && ev_r[`ADCSEQ_E_ENABLE] && trig_event)
            begin
                evpend_r <= 1'b1;
            end
            if (wr_start && en_r)
            begin
                start_r <= 1'b1;
            end
            // flush: abort and restart converter clock
            if (wr_flush)
            begin
                div_r <= 9'h0;
                st_r <= adcseq_pkg::ADCSEQ_IDLE;
            end
            else if (!en_r)
            begin
                div_r <= 9'h0;
                st_r <= adcseq_pkg::ADCSEQ_IDLE;
                start_r <= 1'b0;
                evpend_r <= 1'b0;
            end
            else
            begin
                div_r <= tick ? 9'h0 : div_r + 9'h1;
                case (st_r)
                    adcseq_pkg::ADCSEQ_IDLE:
                    begin
                        if (go && tick)
                        begin
                            st_r <= adcseq_pkg::ADCSEQ_CONV;
                            cyc_r <= total_cyc;
                            start_r <= 1'b0;
                            evpend_r <= 1'b0;
                        end
                    end
                    adcseq_pkg::ADCSEQ_CONV:
                    begin
                        if (tick)
                        begin
                            cyc_r <= cyc_r - 5'h1;
                            if (cyc_r == 5'h1)
                            begin
                                res_r <= fmt;
                                st_r <= cfg_r[`ADCSEQ_B_CONTINUOUS] ? adcseq_pkg::ADCSEQ_WAIT :
                                    adcseq_pkg::ADCSEQ_IDLE;
                            end
                        end
                    end
                    adcseq_pkg::ADCSEQ_WAIT:
                    begin
                        // next conversion on next converter edge
                        if (tick)
                        begin
                            st_r <= adcseq_pkg::ADCSEQ_CONV;
                            cyc_r <= total_cyc;
                            start_r <= 1'b0;
                            evpend_r <= 1'b0;
                        end
                    end
                    default: st_r <= adcseq_pkg::ADCSEQ_IDLE;
                endcase
            end
        end
    end

    // ========================================
    // registered outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conv_clk <= 1'b0;
            sample_en <= 1'b0;
            gain_sample_en <= 1'b0;
            conv_busy <= 1'b0;
            conv_irq <= 1'b0;
            signed_mode <= 1'b0;
            ref_sel <= 3'h0;
            bandgap_en <= 1'b0;
            temp_en <= 1'b0;
            conv_enable <= 1'b0;
        end
        else if (clk_en)
        begin
            // converter clock high in first half
            conv_clk <= en_r && first_half;
            // sample window: first half of first converter cycle after gain
            sample_en <= (st_r == adcseq_pkg::ADCSEQ_CONV) && first_half
                && (cyc_r == total_cyc - gain_cyc);
            // gain stage samples in first half of first cycle
            gain_sample_en <= (st_r == adcseq_pkg::ADCSEQ_CONV) && first_half
                && (gain_cyc != 5'h0) && (cyc_r == total_cyc);
            conv_busy <= (st_r == adcseq_pkg::ADCSEQ_CONV);
            conv_irq <= done_r;
            signed_mode <= cfg_r[`ADCSEQ_B_SIGNED];
            ref_sel <= ref_r[`ADCSEQ_R_SEL_HI:`ADCSEQ_R_SEL_LO];
            bandgap_en <= ref_r[`ADCSEQ_R_BGAP];
            temp_en <= ref_r[`ADCSEQ_R_TEMP];
            conv_enable <= en_r;
        end
    end

    // ========================================
    // assertions
    // no new start while converting
    AST_NO_OVERLAP: assert property (@(posedge hclk) disable iff (!hresetn)
        (st_r == adcseq_pkg::ADCSEQ_CONV) && cyc_r > 5'h1 && clk_en && !wr_flush && en_r
        |=> st_r == adcseq_pkg::ADCSEQ_CONV) else $error("conversion interrupted");
    AST_DONE_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && fire |=> done_r && conv_event) else $error("done flag missing");
    AST_DONE_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && clr_done && !fire |=> !done_r) else $error("done flag not cleared");
    AST_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && !en_r |=> st_r == adcseq_pkg::ADCSEQ_IDLE) else $error("runs while off");
    AST_FLUSH: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_flush |=> div_r == 9'h0 && st_r == adcseq_pkg::ADCSEQ_IDLE)
        else $error("flush ignored");
    AST_START_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && st_r == adcseq_pkg::ADCSEQ_IDLE && go && tick && en_r && !wr_flush
        |=> !start_r && st_r == adcseq_pkg::ADCSEQ_CONV) else $error("start not taken");
    AST_LENGTH: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st_r == adcseq_pkg::ADCSEQ_CONV) |-> cyc_r == total_cyc)
        else $error("wrong conversion length");
    AST_SIGN: assert property (@(posedge hclk) disable iff (!hresetn)
        clk_en && finish && sgn && res_mode == adcseq_pkg::ADCSEQ_TWELVE_BIT_RIGHT
        && en_r && !wr_flush |=> res_r[15:12] == {4{res_r[11]}}) else $error("sign pad");
    COV_CONV: cover property (@(posedge hclk) finish);
    COV_FLUSH: cover property (@(posedge hclk) wr_flush && st_r == adcseq_pkg::ADCSEQ_CONV);
    COV_FREE: cover property (@(posedge hclk) st_r == adcseq_pkg::ADCSEQ_WAIT);
endmodule // adcseq_top

// ---- tb/adcseq_core_model.sv ----
// behavioural analog core: hands a code to the sequencer per conversion
`timescale 1ns/10ps
module adcseq_core_model (
    input wire logic hclk, // peripheral clock
    input wire logic sample_en, // sample window from sequencer
    input wire logic conv_busy, // conversion running
    input wire logic [11:0] code, // analog level, already as a code
    output logic [11:0] core_data // converted code to sequencer
);
    logic [11:0] held_r; // code caught in the sample window
    initial held_r = 12'h000;
    // ==========================
    // sample and present
    // input caught in window
    always @(posedge hclk)
    begin
        if (sample_en === 1'b1)
            held_r <= code;
    end
    // codes are handed over as already calibrated by software
    // outside a conversion the code is not valid: show the inverse
    assign core_data = (conv_busy === 1'b1) ? held_r : ~held_r;
endmodule // adcseq_core_model

// ---- tb/tb_top.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`include "adcseq_defines.svh"
module tb_top;
    logic hclk = 1'b0; // 100 MHz
    logic hresetn = 1'b0; // reset, active low
    logic hsel = 1'b0, hwrite = 1'b0, trig_event = 1'b0, irq_ack = 1'b0;
    logic [11:0] haddr = 12'h000, code = 12'h9a5, core_data;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2, ref_sel;
    logic [31:0] hwdata = 32'h0, hrdata, rd;
    logic hreadyout, hresp, conv_clk, sample_en, gain_sample_en, conv_busy;
    logic conv_irq, conv_event, signed_mode, bandgap_en, temp_en, conv_enable;
    int err_total = 0, checks = 0, ev_cnt = 0, cyc = 0, n, e0, c0, s0, g0;
    int hi_cnt = 0, smp_cnt = 0, gsmp_cnt = 0; // converter clock and sample window counts
    logic clk_en = 1'b1; // clock enable, dropped to freeze the block
    always #5 hclk = ~hclk;
    // ==========================
    // design and analog core
    adcseq_top dut_u (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trig_event(trig_event), .irq_ack(irq_ack), .core_data(core_data),
        .conv_clk(conv_clk), .sample_en(sample_en), .gain_sample_en(gain_sample_en),
        .conv_busy(conv_busy), .conv_irq(conv_irq), .conv_event(conv_event),
        .signed_mode(signed_mode), .ref_sel(ref_sel), .bandgap_en(bandgap_en),
        .temp_en(temp_en), .conv_enable(conv_enable));
    adcseq_core_model core_u (.hclk(hclk), .sample_en(sample_en), .conv_busy(conv_busy),
        .code(code), .core_data(core_data));
    // ==========================
    // event counter and hang guard
    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (conv_event === 1'b1)
            ev_cnt <= ev_cnt + 1;
        if (conv_clk === 1'b1)
            hi_cnt <= hi_cnt + 1;
        if (sample_en === 1'b1)
            smp_cnt <= smp_cnt + 1;
        if (gain_sample_en === 1'b1)
            gsmp_cnt <= gsmp_cnt + 1;
        if (cyc == 60000)
        begin
            err_total++;
            complete_run();
        end
    end
    // ==========================
    // compares and verdict
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_count(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            err_total++;
            $display("MISMATCH %0t count got %0d exp %0d", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========================
    // ahb-lite single word transfers
    task automatic bus_op(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus_op(1'b1, a, d);
    endtask
    // wait for a conversion and count its peripheral clock cycles
    task automatic run_conv(output int len);
        int w;
        w = 0;
        len = 0;
        while (conv_busy !== 1'b1 && w < 3000)
        begin
            @(posedge hclk);
            #1 w++;
        end
        while (conv_busy === 1'b1 && len < 3000)
        begin
            @(posedge hclk);
            #1 len++;
        end
    endtask
    // ==========================
    // scenarios
    task automatic t_reset();
        bus_op(1'b0, `ADCSEQ_OFF_CONTROL_A, 0); chk_word(rd, 0);
        bus_op(1'b0, `ADCSEQ_OFF_CONFIG, 0); chk_word(rd, 0);
        bus_op(1'b0, `ADCSEQ_OFF_REFERENCE, 0); chk_word(rd, 0);
        bus_op(1'b0, 12'h100, 0); chk_word(rd, 0);
        chk_word({conv_enable, signed_mode, bandgap_en, temp_en, ref_sel, hresp}, 0);
    endtask
    task automatic t_reference_select();
        for (int i = 0; i < 4; i++)
        begin
            wr(`ADCSEQ_OFF_REFERENCE, (i << 4) | 3);
            @(posedge hclk);
            #1 chk_word({ref_sel, bandgap_en, temp_en}, (i << 2) | 3);
        end
        wr(`ADCSEQ_OFF_REFERENCE, 32'h1); @(posedge hclk);
        #1 chk_word({bandgap_en, temp_en}, 1);
        wr(`ADCSEQ_OFF_REFERENCE, 32'h2); @(posedge hclk);
        #1 chk_word({bandgap_en, temp_en}, 2);
    endtask
    task automatic t_disabled();
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h4);
        run_conv(n);
        chk_count(n, 0);
    endtask
    task automatic t_single(input logic [31:0] cfg, input int len, input logic [31:0] res);
        wr(`ADCSEQ_OFF_CONFIG, cfg);
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        run_conv(n);
        chk_count(n, len);
        bus_op(1'b0, `ADCSEQ_OFF_RESULT, 0);
        chk_word(rd & 32'hffff, res);
        bus_op(1'b0, `ADCSEQ_OFF_CONTROL_A, 0); chk_word(rd, 1);
        bus_op(1'b0, `ADCSEQ_OFF_FLAGS, 0); chk_word(rd[0], 1);
        chk_word(conv_irq, 1);
        wr(`ADCSEQ_OFF_FLAGS, 32'h1);
        bus_op(1'b0, `ADCSEQ_OFF_FLAGS, 0); chk_word(rd[0], 0);
    endtask
    task automatic t_gain();
        wr(`ADCSEQ_OFF_CONFIG, 32'h0);
        for (int g = 1; g < 7; g++)
        begin
            wr(`ADCSEQ_OFF_GAIN, g);
            s0 = smp_cnt;
            g0 = gsmp_cnt;
            wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
            run_conv(n);
            chk_count(n, (7 + (g + 1) / 2) * 4);
            chk_count(gsmp_cnt - g0, 2);
            chk_count(smp_cnt - s0, 2);
        end
        wr(`ADCSEQ_OFF_GAIN, 0);
    endtask
    // compare mode: flag and event only when the result is above the threshold
    task automatic t_compare();
        wr(`ADCSEQ_OFF_CMP, 32'ha00);
        wr(`ADCSEQ_OFF_FLAGS, 32'h7);
        e0 = ev_cnt;
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        run_conv(n);
        bus_op(1'b0, `ADCSEQ_OFF_FLAGS, 0); chk_word(rd, 6);
        chk_count(ev_cnt - e0, 0);
        wr(`ADCSEQ_OFF_CMP, 32'h900);
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        run_conv(n);
        bus_op(1'b0, `ADCSEQ_OFF_FLAGS, 0); chk_word(rd, 7);
        chk_count(ev_cnt - e0, 1);
        wr(`ADCSEQ_OFF_FLAGS, 32'h1);
    endtask
    // prescaler divide by 8: half of every window high, conversion twice as long
    task automatic t_presc();
        wr(`ADCSEQ_OFF_PRESC, 32'h1);
        repeat (16) @(posedge hclk);
        c0 = hi_cnt;
        repeat (64) @(posedge hclk);
        chk_count(hi_cnt - c0, 32);
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        run_conv(n);
        chk_count(n, 56);
        wr(`ADCSEQ_OFF_PRESC, 32'h0);
    endtask
    // clock enable low for 10 cycles stretches a conversion by 10
    task automatic t_freeze();
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        fork
            run_conv(n);
            begin
                repeat (8) @(posedge hclk);
                clk_en <= 1'b0;
                repeat (10) @(posedge hclk);
                clk_en <= 1'b1;
            end
        join
        chk_count(n, 38);
    endtask
    task automatic t_ack_event();
        wr(`ADCSEQ_OFF_FLAGS, 32'h1);
        wr(`ADCSEQ_OFF_EVCTRL, 32'h1);
        e0 = ev_cnt;
        @(posedge hclk) trig_event <= 1'b1;
        @(posedge hclk) trig_event <= 1'b0;
        run_conv(n);
        chk_count(n, 28);
        chk_count(ev_cnt - e0, 1);
        repeat (2) @(posedge hclk);
        chk_word(conv_irq, 1);
        irq_ack <= 1'b1;
        @(posedge hclk) irq_ack <= 1'b0;
        repeat (2) @(posedge hclk);
        #1 chk_word(conv_irq, 0);
    endtask
    task automatic t_cont_flush();
        e0 = ev_cnt;
        wr(`ADCSEQ_OFF_CONFIG, 32'h8);
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        repeat (200) @(posedge hclk);
        chk_count(ev_cnt - e0 >= 5, 1);
        chk_count(ev_cnt - e0 <= 8, 1);
        wr(`ADCSEQ_OFF_CONFIG, 32'h0);
        repeat (60) @(posedge hclk);
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h5);
        repeat (10) @(posedge hclk);
        e0 = ev_cnt;
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h3);
        repeat (60) @(posedge hclk);
        #1 chk_count(ev_cnt - e0, 0);
        chk_word(conv_busy, 0);
    endtask
    // ==========================
    // main sequence
    initial
    begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_reference_select();
        t_disabled();
        wr(`ADCSEQ_OFF_CONTROL_A, 32'h1);
        @(posedge hclk);
        #1 chk_word(conv_enable, 1);
        t_single(32'h0, 28, 32'h09a5);
        t_single(32'h10, 28, 32'hf9a5);
        chk_word(signed_mode, 1);
        t_single(32'h6, 28, 32'h9a50);
        t_single(32'h4, 20, 32'h009a);
        t_gain();
        t_compare();
        t_presc();
        t_freeze();
        t_ack_event();
        t_cont_flush();
        complete_run();
    end
endmodule // tb_top
